// File: verilog/tcmr_consts.vh
// Constants for the memory region, process id, self-test and test state registers
`ifndef TCMR_CONSTS_VH
`define TCMR_CONSTS_VH
`define TCMR_CRN_REGION    4'h9
`define TCMR_CRN_PROCID    4'hd
`define TCMR_CRN_TEST      4'hf
`define TCMR_CRM_REGION    4'h1
`define TCMR_CRM_PROCID    4'h1
`define TCMR_CRM_TEST      4'h0
`define TCMR_OP2_DATA      3'h0
`define TCMR_OP2_INSTR     3'h1
`define TCMR_OP2_PROCID    3'h1
`define TCMR_OP2_TSTATE    3'h0
`define TCMR_OP2_STCTRL    3'h1
`define TCMR_OP2_I_ADDR    3'h2
`define TCMR_OP2_I_GEN     3'h3
`define TCMR_OP2_D_ADDR    3'h6
`define TCMR_OP2_D_GEN     3'h7
`define TCMR_OP1_TAG       3'h0
`define TCMR_OP1_MEM       3'h1
`define TCMR_OP1_CMEM      3'h2
`define TCMR_BASE_HI       31
`define TCMR_BASE_LO       12
`define TCMR_SIZE_HI       5
`define TCMR_SIZE_LO       1
`define TCMR_SIZE_MIN      5'h03
`define TCMR_SIZE_MAX      5'h17
`define TCMR_SIZE_SHIFT    5'h09
`define TCMR_BASE_RESET    20'h00000
`define TCMR_TS_DC_STREAM  12
`define TCMR_TS_IC_STREAM  11
`define TCMR_TS_DC_FILL    10
`define TCMR_TS_IC_FILL    9
`define TCMR_TS_RESET      4'h0
`define TCMR_PROCID_RESET  32'h00000000
`endif

// File: verilog/tcmr_regs.v
// Memory region, process id, self-test decode and test state register bank
`timescale 1ns/10ps
`include "tcmr_consts.vh"
module tcmr_regs #(
	parameter [4:0] DTCM_PHYS_SIZE = 5'h07,
	parameter [4:0] ITCM_PHYS_SIZE = 5'h07
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire        cp_valid,
	input  wire        cp_write,
	input  wire [2:0]  cp_opc1,
	input  wire [3:0]  cp_crn,
	input  wire [3:0]  cp_crm,
	input  wire [2:0]  cp_opc2,
	input  wire [31:0] cp_wdata,
	input  wire [31:0] acc_addr,
	input  wire        acc_data,
	input  wire        acc_write,
	input  wire        itcm_load_mode,
	input  wire        dtcm_enable,
	output reg  [31:0] cp_rdata,
	output reg         cp_hit,
	output reg  [31:0] trace_process_id_out,
	output reg  [31:0] dtcm_region_out,
	output reg  [31:0] itcm_region_out,
	output reg         acc_sel_itcm,
	output reg         acc_sel_dtcm,
	output reg  [31:0] acc_tcm_offset,
	output reg         dc_no_linefill,
	output reg         ic_no_linefill,
	output reg         dc_no_stream,
	output reg         ic_no_stream
);

	// Self-test control, address and general registers: 3 engines x 5 slots
	localparam NST = 15;

	reg [19:0] dbase_q;
	reg [4:0]  dsize_q;
	reg [4:0]  isize_q;
	reg [31:0] procid_q;
	reg [3:0]  tstate_q;
	reg [31:0] st_q [0:NST-1];

	// Slot index within one self-test engine, or 7 if opcode_2 is not a self-test slot
	function [2:0] st_slot;
		input [2:0] op2;
		begin
			case (op2)
				`TCMR_OP2_STCTRL: st_slot = 3'h0;
				`TCMR_OP2_I_ADDR: st_slot = 3'h1;
				`TCMR_OP2_I_GEN:  st_slot = 3'h2;
				`TCMR_OP2_D_ADDR: st_slot = 3'h3;
				`TCMR_OP2_D_GEN:  st_slot = 3'h4;
				default:          st_slot = 3'h7;
			endcase
		end
	endfunction

	// Mask of address bits that fall inside the visible region for a size code
	function [31:0] size_mask;
		input [4:0] code;
		reg   [4:0] sh;
		begin
			sh = 5'h00;
			if (code < `TCMR_SIZE_MIN) begin
				sh = 5'h00;
			end else if (code > `TCMR_SIZE_MAX) begin
				sh = 5'h17;
			end else begin
				sh = code + `TCMR_SIZE_SHIFT;
			end
			if (code >= `TCMR_SIZE_MAX)
				size_mask = 32'hffffffff;
			else
				size_mask = (32'h00000001 << sh) - 32'h00000001;
		end
	endfunction

	// Clamp an unsupported size code into the 4KB..4GB range
	function [4:0] clamp_size;
		input [4:0] code;
		begin
			if (code < `TCMR_SIZE_MIN)
				clamp_size = `TCMR_SIZE_MIN;
			else if (code > `TCMR_SIZE_MAX)
				clamp_size = `TCMR_SIZE_MAX;
			else
				clamp_size = code;
		end
	endfunction

	wire       sel_dreg   = cp_valid && cp_crn == `TCMR_CRN_REGION && cp_opc1 == 3'h0
		&& cp_crm == `TCMR_CRM_REGION && cp_opc2 == `TCMR_OP2_DATA;
	wire       sel_ireg   = cp_valid && cp_crn == `TCMR_CRN_REGION && cp_opc1 == 3'h0
		&& cp_crm == `TCMR_CRM_REGION && cp_opc2 == `TCMR_OP2_INSTR;
	wire       sel_pid    = cp_valid && cp_crn == `TCMR_CRN_PROCID && cp_opc1 == 3'h0
		&& cp_crm == `TCMR_CRM_PROCID && cp_opc2 == `TCMR_OP2_PROCID;
	wire       sel_ts     = cp_valid && cp_crn == `TCMR_CRN_TEST && cp_opc1 == 3'h0
		&& cp_crm == `TCMR_CRM_TEST && cp_opc2 == `TCMR_OP2_TSTATE;
	wire [2:0] slot       = st_slot(cp_opc2);
	wire       sel_st     = cp_valid && cp_crn == `TCMR_CRN_TEST && cp_crm == `TCMR_CRM_TEST
		&& slot != 3'h7 && cp_opc1 <= `TCMR_OP1_CMEM;
	wire [3:0] st_idx     = cp_opc1[1:0] * 4'h5 + {1'b0, slot};

	// Full register images; unused bits are wired to zero
	wire [31:0] dreg_img  = {dbase_q, 6'h00, dsize_q, 1'b0};
	wire [31:0] ireg_img  = {`TCMR_BASE_RESET, 6'h00, isize_q, 1'b0};
	wire [31:0] ts_img    = {19'h00000, tstate_q, 9'h000};

	reg  [31:0] rdata_d;
	always @* begin
		rdata_d = 32'h00000000;
		if (sel_dreg) begin
			rdata_d = dreg_img;
		end else if (sel_ireg) begin
			rdata_d = ireg_img;
		end else if (sel_pid) begin
			rdata_d = procid_q;
		end else if (sel_ts) begin
			rdata_d = ts_img;
		end else if (sel_st) begin
			rdata_d = st_q[st_idx];
		end
	end

	// Region matching; instruction region always based at zero
	wire [31:0] dmask    = size_mask(dsize_q);
	wire [31:0] imask    = size_mask(isize_q);
	wire        in_dreg  = dtcm_enable && ((acc_addr & ~dmask) == ({dbase_q, 12'h000} & ~dmask));
	wire        in_ireg  = (acc_addr & ~imask) == 32'h00000000;

	reg         sel_i_d;
	reg         sel_d_d;
	always @* begin
		sel_i_d = 1'b0;
		sel_d_d = 1'b0;
		if (acc_data && in_ireg && in_dreg && itcm_load_mode) begin
			sel_i_d = acc_write;
			sel_d_d = !acc_write;
		end else if (in_ireg) begin
			sel_i_d = 1'b1;
		end else if (acc_data && in_dreg) begin
			sel_d_d = 1'b1;
		end
	end

	// Physical offset; aliasing arises from the memory's own address wrap
	wire [31:0] offs_d = acc_addr & (sel_i_d ? imask : dmask);

	always @(posedge clock) begin
		if (!rst_n) begin
			dbase_q              <= `TCMR_BASE_RESET;
			dsize_q              <= DTCM_PHYS_SIZE;
			isize_q              <= ITCM_PHYS_SIZE;
			procid_q             <= `TCMR_PROCID_RESET;
			tstate_q             <= `TCMR_TS_RESET;
			cp_rdata             <= 32'h00000000;
			cp_hit               <= 1'b0;
			trace_process_id_out <= `TCMR_PROCID_RESET;
			dtcm_region_out      <= 32'h00000000;
			itcm_region_out      <= 32'h00000000;
			acc_sel_itcm         <= 1'b0;
			acc_sel_dtcm         <= 1'b0;
			acc_tcm_offset       <= 32'h00000000;
			dc_no_linefill       <= 1'b0;
			ic_no_linefill       <= 1'b0;
			dc_no_stream         <= 1'b0;
			ic_no_stream         <= 1'b0;
		end else if (clk_en) begin
			if (cp_write && sel_dreg) begin
				dbase_q <= cp_wdata[`TCMR_BASE_HI:`TCMR_BASE_LO];
				dsize_q <= clamp_size(cp_wdata[`TCMR_SIZE_HI:`TCMR_SIZE_LO]);
			end
			if (cp_write && sel_ireg)
				isize_q <= clamp_size(cp_wdata[`TCMR_SIZE_HI:`TCMR_SIZE_LO]);
			if (cp_write && sel_pid)
				procid_q <= cp_wdata;
			if (cp_write && sel_ts)
				tstate_q <= cp_wdata[`TCMR_TS_DC_STREAM:`TCMR_TS_IC_FILL];
			cp_rdata             <= cp_write ? 32'h00000000 : rdata_d;
			cp_hit               <= sel_dreg | sel_ireg | sel_pid | sel_ts | sel_st;
			trace_process_id_out <= procid_q;
			dtcm_region_out      <= dreg_img;
			itcm_region_out      <= ireg_img;
			acc_sel_itcm         <= sel_i_d;
			acc_sel_dtcm         <= sel_d_d;
			acc_tcm_offset       <= offs_d;
			// Cache controller uses these to skip allocation and hold the word back
			dc_no_stream         <= tstate_q[3];
			ic_no_stream         <= tstate_q[2];
			dc_no_linefill       <= tstate_q[1];
			ic_no_linefill       <= tstate_q[0];
		end
	end

	// Self-test register storage; no reset, contents only matter to test engines
	genvar gi;
	generate
		for (gi = 0; gi < NST; gi = gi + 1) begin : g_st
			always @(posedge clock) begin
				if (clk_en && cp_write && sel_st && st_idx == gi)
					st_q[gi] <= cp_wdata;
			end
		end
	endgenerate

endmodule // tcmr_regs

// File: dv/tcmr_regs_chk.sv
// Assertion checker for the region, process id and test state register bank
`timescale 1ns/10ps
module tcmr_regs_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        cp_valid,
	input wire logic        cp_write,
	input wire logic [2:0]  cp_opc1,
	input wire logic [3:0]  cp_crn,
	input wire logic [3:0]  cp_crm,
	input wire logic [2:0]  cp_opc2,
	input wire logic [31:0] cp_wdata,
	input wire logic [31:0] cp_rdata,
	input wire logic        cp_hit,
	input wire logic [31:0] trace_process_id_out,
	input wire logic [31:0] itcm_region_out,
	input wire logic        dc_no_stream,
	input wire logic        ic_no_stream,
	input wire logic        dc_no_linefill,
	input wire logic        ic_no_linefill
);
	wire go = clk_en & cp_valid & (cp_opc1 == 3'h0);
	wire rg_sel = go && cp_crn == 4'h9 && cp_crm == 4'h1 && cp_opc2 <= 3'h1;
	wire ts_sel = go && cp_crn == 4'hf && cp_crm == 4'h0 && cp_opc2 == 3'h0;
	wire pid_wr = go && cp_write && cp_crn == 4'hd && cp_crm == 4'h1 && cp_opc2 == 3'h1;
	logic [3:0] ts_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Shadow of the last test state write, for the bit and read-back checks
	always @(posedge clock)
		if (!rst_n)
			ts_q <= 4'h0;
		else if (ts_sel && cp_write)
			ts_q <= cp_wdata[12:9];
	sequence s_ts_show;
		##1 {dc_no_stream, ic_no_stream, dc_no_linefill, ic_no_linefill} == ts_q;
	endsequence
	region_hit_a: assert property (rg_sel |=> cp_hit)
		else $error("no hit after region access");
	ibase_zero_a: assert property (itcm_region_out[31:12] == 20'h0)
		else $error("instruction base not zero");
	region_rsvd_a: assert property (itcm_region_out[11:6] == 6'h0 && !itcm_region_out[0])
		else $error("region reserved bits set");
	size_range_a: assert property ($past(rst_n, 2) |-> itcm_region_out[5:1] inside {[5'h03:5'h17]})
		else $error("size code out of range");
	unmapped_zero_a: assert property (go && cp_crn == 4'h9 && cp_crm == 4'h2 |=> !cp_hit && cp_rdata == 32'h0)
		else $error("unmapped access answered");
	pid_trace_a: assert property (pid_wr |=> ##1 trace_process_id_out == $past(cp_wdata, 2))
		else $error("trace pins do not follow process id");
	ts_bits_a: assert property (ts_sel && cp_write |=> s_ts_show)
		else $error("test state outputs wrong");
	ts_read_a: assert property (ts_sel && !cp_write |=> cp_rdata == {19'h0, ts_q, 9'h0})
		else $error("test state read wrong");
endmodule // tcmr_regs_chk
bind tcmr_regs tcmr_regs_chk u_chk(.*);

// File: dv/tcmr_core_model.sv
// Core side model issuing coprocessor register transfers
`timescale 1ns/10ps
module tcmr_core_model (
	input  wire logic        clock,
	output logic             clk_en,
	output logic             cp_valid,
	output logic             cp_write,
	output logic [2:0]       cp_opc1,
	output logic [3:0]       cp_crn,
	output logic [3:0]       cp_crm,
	output logic [2:0]       cp_opc2,
	output logic [31:0]      cp_wdata
);
	initial begin
		{cp_valid, cp_write, cp_opc1, cp_crn, cp_crm, cp_opc2, cp_wdata} = '0;
		clk_en = 1'b1;
	end
	// Idle data is inverted so a stale word is never mistaken for a live one
	task xfer(input logic w, input logic [13:0] sel, input logic [31:0] d);
		@(negedge clock);
		{cp_valid, cp_write, cp_opc1, cp_crn, cp_crm, cp_opc2, cp_wdata} = {1'b1, w, sel, d};
		@(negedge clock);
		cp_valid = 1'b0;
		cp_wdata = ~d;
	endtask
endmodule // tcmr_core_model

// File: dv/tcm_region_and_test_state_regs_tb_top.sv
// Self-checking bench for the region, process id, self-test and test state registers
`timescale 1ns/10ps
module tcm_region_and_test_state_regs_tb_top;
	localparam logic [13:0] DREG = 14'h0488, IREG = 14'h0489, PID = 14'h0689;
	localparam logic [13:0] TST = 14'h0780, UNMAP = 14'h0490;
	logic        clock, rst_n, clk_en, cp_valid, cp_write, acc_data, acc_write, rd_q;
	logic        itcm_load_mode, dtcm_enable, cp_hit, acc_sel_itcm, acc_sel_dtcm;
	logic        dc_no_linefill, ic_no_linefill, dc_no_stream, ic_no_stream;
	logic [2:0]  cp_opc1, cp_opc2;
	logic [3:0]  cp_crn, cp_crm;
	logic [31:0] cp_wdata, acc_addr, cp_rdata, trace_process_id_out, rnd;
	logic [31:0] dtcm_region_out, itcm_region_out, acc_tcm_offset;
	logic [32:0] exp_q[$];
	logic [2:0]  op2s [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	int          bad_count, n_compared, i;
	tcmr_regs u_dut(.*);
	tcmr_core_model u_core(.*);
	task chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task wr(input logic [13:0] sel, input logic [31:0] d);
		u_core.xfer(1'b1, sel, d);
	endtask
	task rd(input logic [13:0] sel, input logic [32:0] e);
		exp_q.push_back(e);
		u_core.xfer(1'b0, sel, 32'h0);
	endtask
	task route(input logic [31:0] a, input logic w, input logic lm, input logic [1:0] e,
		input logic [31:0] o);
		@(negedge clock);
		{acc_addr, acc_data, acc_write, itcm_load_mode} = {a, 1'b1, w, lm};
		@(negedge clock);
		chk({31'h0, acc_sel_itcm, acc_sel_dtcm}, {31'h0, e}, "route");
		if (e != 2'b00) chk({1'b0, acc_tcm_offset}, {1'b0, o}, "offset");
		acc_data = 1'b0;
	endtask
	task finish_test();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Read answers land one edge after the transfer is taken
	always @(posedge clock) begin
		if (rd_q && exp_q.size() > 0)
			chk({cp_hit, cp_rdata}, exp_q.pop_front(), "rdata");
		rd_q <= cp_valid & ~cp_write;
	end
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
	initial begin
		{rst_n, acc_data, acc_write, itcm_load_mode, dtcm_enable, acc_addr} = '0;
		rnd = 32'h75c4d741;
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		rd(DREG, {1'b1, 32'h0000000e});
		rd(IREG, {1'b1, 32'h0000000e});
		wr(DREG, 32'h00010fcb);
		rd(DREG, {1'b1, 32'h0001000a});
		rd(UNMAP, 33'h0);
		wr(IREG, 32'h00000010);
		rd(IREG, {1'b1, 32'h00000010});
		for (i = 3; i < 24; i++) begin
			rnd = lfsr(rnd);
			wr(DREG, {20'h0, rnd[11:6], i[4:0], rnd[0]});
			rd(DREG, {1'b1, 26'h0, i[4:0], 1'b0});
		end
		rnd = lfsr(rnd);
		wr(PID, rnd);
		rd(PID, {1'b1, rnd});
		chk({1'b0, trace_process_id_out}, {1'b0, rnd}, "procid");
		// A write while the clock enable is low must leave the register frozen
		u_core.clk_en = 1'b0;
		wr(PID, ~rnd);
		u_core.clk_en = 1'b1;
		rd(PID, {1'b1, rnd});
		chk({1'b0, trace_process_id_out}, {1'b0, rnd}, "procid");
		for (i = 0; i < 15; i++) begin
			rnd = lfsr(rnd);
			wr({3'(i / 5), 8'hf0, op2s[i % 5]}, rnd);
			rd({3'(i / 5), 8'hf0, op2s[i % 5]}, {1'b1, rnd});
		end
		wr(TST, 32'hffffffff);
		rd(TST, {1'b1, 32'h00001e00});
		chk({29'h0, dc_no_stream, ic_no_stream, dc_no_linefill, ic_no_linefill}, 33'hf, "ts");
		wr(TST, 32'h00001400);
		rd(TST, {1'b1, 32'h00001400});
		chk({29'h0, dc_no_stream, ic_no_stream, dc_no_linefill, ic_no_linefill}, 33'ha, "ts");
		wr(DREG, 32'h00100012);
		dtcm_enable = 1'b1;
		route(32'h00000100, 1'b0, 1'b0, 2'b10, 32'h00000100);
		chk({1'b0, dtcm_region_out}, {1'b0, 32'h00100012}, "dimg");
		route(32'h00130004, 1'b0, 1'b0, 2'b01, 32'h00030004);
		route(32'h00140000, 1'b0, 1'b0, 2'b00, 32'h00000000);
		dtcm_enable = 1'b0;
		wr(DREG, 32'h0000000e);
		dtcm_enable = 1'b1;
		route(32'h00000100, 1'b0, 1'b0, 2'b10, 32'h00000100);
		route(32'h00000100, 1'b0, 1'b1, 2'b01, 32'h00000100);
		route(32'h00000100, 1'b1, 1'b1, 2'b10, 32'h00000100);
		finish_test();
	end
endmodule // tcm_region_and_test_state_regs_tb_top
